// *** ioc_osc_top.sv ***
// internal oscillator, master clock selection and clock net muxes
// assumes: i_mclk is the raw 125 MHz source, all inputs synchronous
// Overview of operation
// - oscillator output feeds clock tree or pll reference
// - user divider derives slower clock enables
// - oscillator runs when program bit and user enable
// - default frequency 2.08 MHz after reset
// - switch to selected frequency when bits received
// - no selection keeps the default frequency
// - twenty-one fixed nominal frequency choices
// - eight secondary nets from 8:1 muxes
// - primary mux 27:1 large, 17:1 small
`timescale 1ns/1ps
module ioc_osc_top #(
    parameter bit LARGE_DEV = 1'b1,
    parameter int PRI_IN = LARGE_DEV ? ioc_pkg::PRI_MUX_IN_LARGE : ioc_pkg::PRI_MUX_IN_SMALL
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_prog_osc_en,
    input wire logic i_user_osc_en,
    input wire ioc_pkg::ioc_cfg_t i_cfg,
    input wire logic i_ref_sel,
    input wire logic [15:0] i_user_div,
    input wire logic [ioc_pkg::SEC_NETS-1:0] i_sec_pin,
    input wire logic [ioc_pkg::SEC_NETS*7-1:0] i_sec_route,
    input wire logic [ioc_pkg::SEC_NETS*3-1:0] i_sec_sel,
    input wire logic [PRI_IN-2:0] i_pri_route,
    input wire logic [4:0] i_pri_sel,
    output logic o_osc_clk,
    output logic o_pll_ref,
    output logic o_user_ce,
    output logic [4:0] o_active_sel,
    output logic [ioc_pkg::SEC_NETS-1:0] o_sec_net,
    output logic o_pri_net
);
    ioc_pkg::ioc_state_t st_r;
    ioc_pkg::ioc_state_t st_nxt;
    logic run;

    function automatic logic [4:0] clamp_sel(input logic [4:0] sel);
        return (sel < 5'(ioc_pkg::NUM_FREQ)) ? sel : ioc_pkg::FREQ_SEL_DEFAULT;
    endfunction

    function automatic logic [15:0] half_of(input logic [4:0] sel);
        int hz;
        int h;
        hz = ioc_pkg::FREQ_KHZ[clamp_sel(sel)] * 1000;
        h = ioc_pkg::MCLK_HZ / (2 * hz);
        if (h < 1) begin
            h = 1;
        end
        return 16'(h);
    endfunction

    assign run = i_prog_osc_en && i_user_osc_en;

    always_comb begin
        st_nxt = st_r;
        st_nxt.user_en = 1'b0;
        if (i_cfg.load) begin
            st_nxt.pend = 1'b1;
            st_nxt.pend_sel = clamp_sel(i_cfg.sel);
        end
        if (!run) begin
            st_nxt.osc_clk = 1'b0;
            st_nxt.cnt = 16'h0000;
        end else if (st_r.cnt + 16'h0001 >= st_r.half_ticks) begin
            st_nxt.cnt = 16'h0000;
            st_nxt.osc_clk = !st_r.osc_clk;
            // switch only at the falling edge: no runt pulse
            if (st_r.osc_clk && (st_r.pend || i_cfg.load)) begin
                st_nxt.active_sel = st_nxt.pend_sel;
                st_nxt.half_ticks = half_of(st_nxt.pend_sel);
                st_nxt.pend = 1'b0;
            end
            if (!st_r.osc_clk) begin
                // divider counts oscillator rising edges
                if (st_r.ucnt >= i_user_div) begin
                    st_nxt.ucnt = 16'h0000;
                    st_nxt.user_en = 1'b1;
                end else begin
                    st_nxt.ucnt = st_r.ucnt + 16'h0001;
                end
            end
        end else begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
        st_nxt.ref_en = i_ref_sel;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            st_r.half_ticks <= half_of(ioc_pkg::FREQ_SEL_DEFAULT);
            st_r.cnt <= 16'h0000;
            st_r.ucnt <= ioc_pkg::USER_DIV_RESET;
            st_r.active_sel <= ioc_pkg::FREQ_SEL_DEFAULT;
            st_r.pend_sel <= ioc_pkg::FREQ_SEL_DEFAULT;
            st_r.pend <= 1'b0;
            st_r.osc_clk <= 1'b0;
            st_r.user_en <= 1'b0;
            st_r.ref_en <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // oscillator to clock tree or pll reference
    assign o_osc_clk = st_r.ref_en ? 1'b0 : st_r.osc_clk;
    assign o_pll_ref = st_r.ref_en ? st_r.osc_clk : 1'b0;
    assign o_user_ce = st_r.user_en;
    assign o_active_sel = st_r.active_sel;

    // secondary nets: pin input 0, routing 1..7
    for (genvar g = 0; g < ioc_pkg::SEC_NETS; g++) begin : g_sec
        ioc_clk_mux #(.N(ioc_pkg::SEC_MUX_IN), .SW(3)) u_sec (
            .i_mclk(i_mclk),
            .i_nrst(i_nrst),
            .i_in({i_sec_route[g*7 +: 7], i_sec_pin[g]}),
            .i_sel(i_sec_sel[g*3 +: 3]),
            .o_net(o_sec_net[g])
        );
        chk_sec_each_pin: assert property (@(posedge i_mclk) disable iff (!i_nrst)
            i_sec_sel[g*3 +: 3] == 3'h0 |=> o_sec_net[g] == $past(i_sec_pin[g]))
            else $error("secondary net not from its pin");
        chk_sec_each_top: assert property (@(posedge i_mclk) disable iff (!i_nrst)
            i_sec_sel[g*3 +: 3] == 3'h7 |=> o_sec_net[g] == $past(i_sec_route[g*7+6]))
            else $error("secondary net not from its last route");
    end

    // primary net: oscillator plus routing inputs
    ioc_clk_mux #(.N(PRI_IN), .SW(5)) u_pri (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_in({i_pri_route, st_r.osc_clk}),
        .i_sel(i_pri_sel),
        .o_net(o_pri_net)
    );

    chk_default_after_reset: assert property (@(posedge i_mclk)
        $rose(i_nrst) |-> o_active_sel == ioc_pkg::FREQ_SEL_DEFAULT)
        else $error("active selection not default after reset");
    chk_osc_off_stops: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !run |=> !st_r.osc_clk)
        else $error("oscillator ran while disabled");
    chk_switch_on_low: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $changed(st_r.active_sel) |-> !st_r.osc_clk && $past(st_r.osc_clk))
        else $error("frequency switched outside falling edge");
    chk_no_cfg_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !st_r.pend && !i_cfg.load |=> $stable(st_r.active_sel))
        else $error("frequency changed with no selection");
    chk_sel_in_range: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        st_r.active_sel < 5'(ioc_pkg::NUM_FREQ))
        else $error("selection out of table");
    chk_route_excl: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !(o_osc_clk && o_pll_ref))
        else $error("oscillator on both destinations");
    chk_user_ce_pulse: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        o_user_ce |=> !o_user_ce)
        else $error("user enable longer than one cycle");
    chk_sec_pin: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_sec_sel[2:0] == 3'h0 |=> o_sec_net[0] == $past(i_sec_pin[0]))
        else $error("secondary net 0 not from pin");
    chk_switch_soon: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        st_r.pend && run |-> ##[0:61] (!st_r.pend || !run))
        else $error("pending frequency not applied");
    chk_no_runt: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $past(i_nrst) && $past(run) && $changed(st_r.osc_clk)
        |-> $past(st_r.cnt) + 16'h0001 == $past(st_r.half_ticks))
        else $error("oscillator phase shorter than its half period");
    chk_cnt_bound: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        st_r.cnt < st_r.half_ticks)
        else $error("phase counter past its half period");
    chk_half_match: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        st_r.half_ticks == half_of(st_r.active_sel))
        else $error("half period does not match active selection");
    chk_pend_sel_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !i_cfg.load |=> $stable(st_r.pend_sel))
        else $error("pending selection changed with no load");
    chk_load_capture: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_cfg.load |=> st_r.pend_sel == (($past(i_cfg.sel) < 5'(ioc_pkg::NUM_FREQ))
            ? $past(i_cfg.sel) : ioc_pkg::FREQ_SEL_DEFAULT))
        else $error("loaded selection not captured");
    chk_no_load_idle: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !st_r.pend && !i_cfg.load |=> !st_r.pend)
        else $error("switch pending with no selection");
    chk_osc_start_low: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $rose(run) |-> !st_r.osc_clk && st_r.cnt == 16'h0000)
        else $error("oscillator not restarted from low");
    chk_off_no_ce: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !run |=> !o_user_ce)
        else $error("user enable while oscillator off");
    chk_ce_on_rise: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        o_user_ce |-> st_r.osc_clk && !$past(st_r.osc_clk))
        else $error("user enable not on oscillator rise");
    chk_ce_div_reached: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        o_user_ce |-> $past(st_r.ucnt) >= $past(i_user_div))
        else $error("user enable before divider count");
    chk_ref_route: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $past(i_nrst) && $past(i_ref_sel) |-> !o_osc_clk && o_pll_ref == st_r.osc_clk)
        else $error("oscillator not on pll reference");
    chk_tree_route: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $past(i_nrst) && !$past(i_ref_sel) |-> !o_pll_ref && o_osc_clk == st_r.osc_clk)
        else $error("oscillator not on clock tree");
    chk_pri_osc: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_pri_sel == 5'h00 |=> o_pri_net == $past(st_r.osc_clk))
        else $error("primary input 0 not the oscillator");
    chk_pri_range: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        32'(i_pri_sel) >= PRI_IN |=> !o_pri_net)
        else $error("primary net driven by missing input");
    chk_sec_route: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_sec_sel[2:0] == 3'h1 |=> o_sec_net[0] == $past(i_sec_route[0]))
        else $error("secondary net 0 not from first route");

    // coverage of the main scenarios
    cov_switch: cover property (@(posedge i_mclk) $changed(st_r.active_sel));
    cov_user_ce: cover property (@(posedge i_mclk) o_user_ce);
    cov_pll_ref: cover property (@(posedge i_mclk) o_pll_ref);
    cov_osc_stopped: cover property (@(posedge i_mclk) run ##1 !run);
    cov_pri_osc: cover property (@(posedge i_mclk) i_pri_sel == 5'h00 ##1 o_pri_net);
endmodule

// *** ioc_pkg.sv ***
// package: constants and carrier types for the oscillator clock block
// assumes: one 125 MHz system clock, synchronous active-low reset
package ioc_pkg;
    localparam int MCLK_HZ = 125000000;
    localparam int FREQ_SEL_W = 5;
    localparam int NUM_FREQ = 21;
    localparam logic [4:0] FREQ_SEL_DEFAULT = 5'h00;
    localparam int DIV_W = 16;
    localparam logic [15:0] USER_DIV_RESET = 16'h0000;
    localparam int SEC_NETS = 8;
    localparam int SEC_MUX_IN = 8;
    localparam int PRI_MUX_IN_LARGE = 27;
    localparam int PRI_MUX_IN_SMALL = 17;
    // nominal frequencies in kHz, index 0 is the default 2.08 MHz
    localparam int FREQ_KHZ [0:20] = '{2080, 2460, 3170, 4290, 5540, 7000, 8310,
        9170, 10230, 13300, 14780, 20460, 26600, 29560,
        33250, 38000, 44330, 53200, 66500, 88670, 133000};

    typedef struct packed {
        logic [4:0] sel;
        logic load;
    } ioc_cfg_t;

    typedef struct packed {
        logic [15:0] half_ticks;
        logic [15:0] cnt;
        logic [15:0] ucnt;
        logic [4:0] active_sel;
        logic [4:0] pend_sel;
        logic pend;
        logic osc_clk;
        logic user_en;
        logic ref_en;
    } ioc_state_t;
endpackage

// *** ioc_clk_mux.sv ***
// clock net multiplexer: one of N inputs routed to one net
// assumes: select stable from the enclosing logic, registered output
`timescale 1ns/1ps
module ioc_clk_mux #(
    parameter int N = 8,
    parameter int SW = 3
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic [N-1:0] i_in,
    input wire logic [SW-1:0] i_sel,
    output logic o_net
);
    logic net_r;
    logic net_nxt;
    always_comb begin
        net_nxt = 1'b0;
        if (32'(i_sel) < N) begin
            net_nxt = i_in[i_sel];
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            net_r <= 1'b0;
        end else begin
            net_r <= net_nxt;
        end
    end
    assign o_net = net_r;
endmodule

// *** ioc_osc_top_tb.sv ***
// testbench for the oscillator clock block
// assumes: ioc_pkg compiled first, large device build
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module ioc_osc_top_tb;
    logic i_mclk, i_nrst, i_prog_osc_en, i_user_osc_en, i_ref_sel;
    ioc_pkg::ioc_cfg_t i_cfg;
    logic [15:0] i_user_div;
    logic [7:0] i_sec_pin, o_sec_net, e8;
    logic [55:0] i_sec_route;
    logic [23:0] i_sec_sel;
    logic [25:0] i_pri_route;
    logic [4:0] i_pri_sel, o_active_sel, prev_sel;
    logic o_osc_clk, o_pll_ref, o_user_ce, o_pri_net;
    logic [4:0] exp_q[$];
    int n_fail = 0, check_count = 0, n, a, b, c;
    int tbl[5] = '{9, 25, 0, 0, 20};
    ioc_osc_top u_ioc_osc_top (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_prog_osc_en(i_prog_osc_en),
        .i_user_osc_en(i_user_osc_en), .i_cfg(i_cfg), .i_ref_sel(i_ref_sel), .i_user_div(i_user_div),
        .i_sec_pin(i_sec_pin), .i_sec_route(i_sec_route), .i_sec_sel(i_sec_sel),
        .i_pri_route(i_pri_route), .i_pri_sel(i_pri_sel), .o_osc_clk(o_osc_clk), .o_pll_ref(o_pll_ref),
        .o_user_ce(o_user_ce), .o_active_sel(o_active_sel), .o_sec_net(o_sec_net), .o_pri_net(o_pri_net));
    initial begin
        i_mclk = 0;
        forever #4 i_mclk = ~i_mclk;
    end
    task results;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // active frequency monitor: each change takes the oldest note
    always @(negedge i_mclk) begin
        if (!i_nrst) prev_sel = o_active_sel;
        else if (o_active_sel !== prev_sel) begin
            prev_sel = o_active_sel;
            if (exp_q.size() > 0) `CHK(o_active_sel, exp_q.pop_front())
            else `CHK(1'b1, 1'b0)
        end
    end
    task clk1;
        @(posedge i_mclk);
        #1;
    endtask
    task period(output int p);
        time t0;
        @(posedge o_osc_clk);
        t0 = $time;
        @(posedge o_osc_clk);
        p = int'(($time - t0) / 8);
        #1;
    endtask
    task watch(input int cyc);
        a = 0; b = 0; c = 0;
        repeat (cyc) begin
            clk1();
            a += o_osc_clk; b += o_pll_ref; c += o_user_ce;
        end
    endtask
    initial begin
        #100000;
        n_fail++;
        results();
    end
    initial begin
        i_nrst = 0; i_prog_osc_en = 1; i_user_osc_en = 1; i_ref_sel = 0; i_cfg = '0; i_user_div = 16'h0003;
        i_sec_pin = '0; i_sec_route = '0; i_sec_sel = '0; i_pri_route = '0; i_pri_sel = 5'h00;
        void'($urandom(32'h9ed6b083));
        repeat (6) clk1();
        i_nrst = 1;
        period(n);
        `CHK(n, 60)
        `CHK(o_active_sel, 5'h00)
        $display("default frequency done");
        tbl[2] = 1 + $urandom % 19;
        foreach (tbl[k]) begin
            i_cfg = '{sel: 5'(tbl[k]), load: 1'b1};
            exp_q.push_back(tbl[k] > 20 ? 5'h00 : 5'(tbl[k]));
            clk1();
            i_cfg.load = 0;
            repeat (70) clk1();
            if (tbl[k] == 9) begin
                period(n);
                `CHK(n, 8)
            end
        end
        `CHK(exp_q.size(), 0)
        $display("frequency select done");
        for (int e = 0; e < 3; e++) begin
            i_prog_osc_en = (e != 0); i_user_osc_en = (e != 1); i_ref_sel = (e == 2);
            repeat (5) clk1();
            watch(80);
            `CHK(a, 0)
            `CHK(b > 0, e == 2)
        end
        i_ref_sel = 0;
        repeat (5) clk1();
        watch(80);
        `CHK(c >= 9 && c <= 11, 1'b1)
        `CHK(a > 0, 1'b1)
        $display("enable routing divider done");
        for (int s = 0; s < 32; s++) begin
            i_sec_pin = 8'($urandom); i_sec_route = 56'({$urandom, $urandom}); i_pri_route = 26'($urandom);
            i_sec_sel = {8{3'(s)}}; i_pri_sel = 5'(s);
            for (int g = 0; g < 8; g++) e8[g] = (s % 8 == 0) ? i_sec_pin[g] : i_sec_route[g * 7 + s % 8 - 1];
            clk1();
            clk1();
            `CHK(o_sec_net, e8)
            if (s > 0) `CHK(o_pri_net, s < 27 ? i_pri_route[s - 1] : 1'b0)
        end
        $display("clock mux done");
        i_nrst = 0;
        repeat (2) clk1();
        `CHK(o_active_sel, 5'h00)
        i_nrst = 1;
        period(n);
        `CHK(n, 60)
        $display("mid-run reset done");
        results();
    end
endmodule
